//--- core/fieldbus_sync_pkg.sv
// Functional notes
// - Free-run mode applies incoming process data at once, no sync event.
// - Free-run only with asynchronous motion modes, never cyclic synchronous.
// - Distributed-clock mode captures received process data on arrival.
// - Distributed-clock mode holds captured data until the sync event.
// - Decode and control computation finish before the next sync event.
// - Prepared control action applied on the sync event, no added delay.
// - Upward changes go one level at a time; skipping requests refused.
// - Downward changes may jump straight to any lower level.
// - A requested change that cannot complete reports an error to master.
// - Init state exchanges no mailbox or process data traffic.
// - Pre-Operational serves mailbox and SDO only; no process data.
// - Safe-Operational serves mailbox and transmit PDOs; receive stays off.
// - Operational serves mailbox, receive and transmit PDO exchange.
// - Classic SDO transfers carry at most eight payload bytes.
// - Mailbox SDO keeps its header unchanged; payload may be enlarged.
// - Receive PDOs flow master to device; transmit PDOs device to master.
// - Distributed-clock mode refreshes PDO contents once per sync cycle.
// - Free-run mode updates PDO contents whenever new data arrives.
package fieldbus_sync_pkg;

	typedef enum logic [1:0]
	{
		ST_INIT,
		ST_PREOP,
		ST_SAFEOP,
		ST_OP
	} comm_state_t;

	localparam logic [1:0] ERR_NONE   = 2'h0;
	localparam logic [1:0] ERR_SKIP   = 2'h1;
	localparam logic [1:0] ERR_CONFIG = 2'h2;

	localparam int CLASSIC_SDO_BYTES = 8;
	localparam int MBX_MAX_BYTES     = 128;
	localparam int MBX_LEN_W         = 8;
	localparam int MBX_HDR_W         = 16;
	localparam int PDO_W             = 64;
	localparam int DECODE_LAT        = 4;
	localparam int CLK_PERIOD_NS     = 40;

endpackage : fieldbus_sync_pkg

//--- core/pdo_decode.sv
`timescale 1ns/1ns
// Multi-cycle decode stage; a new start restarts with the newest data.
module pdo_decode #(
	parameter int W   = fieldbus_sync_pkg::PDO_W,
	parameter int LAT = fieldbus_sync_pkg::DECODE_LAT
)(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         start,
	input  wire logic [W-1:0] din,
	output logic              busy,
	output logic              done,
	output logic [W-1:0]      dout
);
	localparam int CW = $clog2(LAT + 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [W-1:0]  data_reg;
	logic [W-1:0]  data_next;
	logic          done_reg;
	logic          done_next;

	always_comb
	begin
		cnt_next  = cnt_reg;
		data_next = data_reg;
		done_next = 1'b0;
		if (start)
		begin
			// Captured on arrival, not on the sync event
			data_next = din;
			cnt_next  = CW'(LAT);
		end
		else if (cnt_reg != '0)
		begin
			cnt_next  = cnt_reg - CW'(1);
			done_next = (cnt_reg == CW'(1));
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_reg  <= '0;
			data_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			data_reg <= data_next;
			done_reg <= done_next;
		end
	end

	assign busy = (cnt_reg != '0);
	assign done = done_reg;
	assign dout = data_reg;

endmodule : pdo_decode

//--- core/fieldbus_slave_state_sync.sv
`timescale 1ns/1ns
module fieldbus_slave_state_sync #(
	parameter int PDO_W   = fieldbus_sync_pkg::PDO_W,
	parameter int DEC_LAT = fieldbus_sync_pkg::DECODE_LAT,
	parameter int MBX_MAX = fieldbus_sync_pkg::MBX_MAX_BYTES
)(
	input  wire logic                                   clk,
	input  wire logic                                   nrst,
	input  wire logic                                   dc_mode,
	input  wire logic                                   cyclic_mode,
	input  wire logic                                   sync0,
	input  wire logic                                   req_valid,
	input  wire fieldbus_sync_pkg::comm_state_t         req_state,
	output fieldbus_sync_pkg::comm_state_t              comm_state,
	output logic                                        req_ack,
	output logic                                        req_err,
	output logic [1:0]                                  req_err_code,
	input  wire logic                                   mbx_valid,
	output logic                                        mbx_ready,
	input  wire logic                                   mbx_classic,
	input  wire logic [fieldbus_sync_pkg::MBX_HDR_W-1:0] mbx_hdr,
	input  wire logic [fieldbus_sync_pkg::MBX_LEN_W-1:0] mbx_len,
	output logic                                        mbx_reject,
	output logic                                        sdo_valid,
	input  wire logic                                   sdo_ready,
	output logic [fieldbus_sync_pkg::MBX_HDR_W-1:0]     sdo_hdr,
	output logic [fieldbus_sync_pkg::MBX_LEN_W-1:0]     sdo_len,
	input  wire logic                                   rx_valid,
	output logic                                        rx_ready,
	input  wire logic [PDO_W-1:0]                       rx_data,
	output logic                                        drive_cmd_valid,
	output logic [PDO_W-1:0]                            drive_cmd,
	output logic                                        late_fault,
	output logic                                        data_miss,
	output logic                                        mode_fault,
	input  wire logic                                   status_strobe,
	input  wire logic [PDO_W-1:0]                       drive_status,
	output logic                                        tx_valid,
	input  wire logic                                   tx_ready,
	output logic [PDO_W-1:0]                            tx_data
);
	typedef fieldbus_sync_pkg::comm_state_t st_t;
	localparam int LW = fieldbus_sync_pkg::MBX_LEN_W;

	function automatic st_t up_one(input st_t s);
		case (s)
			fieldbus_sync_pkg::ST_INIT:   return fieldbus_sync_pkg::ST_PREOP;
			fieldbus_sync_pkg::ST_PREOP:  return fieldbus_sync_pkg::ST_SAFEOP;
			default:                      return fieldbus_sync_pkg::ST_OP;
		endcase
	endfunction : up_one

	function automatic logic mbx_ok(input st_t s);
		return s != fieldbus_sync_pkg::ST_INIT;
	endfunction : mbx_ok

	function automatic logic txpdo_ok(input st_t s);
		return s == fieldbus_sync_pkg::ST_SAFEOP ||
			s == fieldbus_sync_pkg::ST_OP;
	endfunction : txpdo_ok

	function automatic logic rxpdo_ok(input st_t s);
		return s == fieldbus_sync_pkg::ST_OP;
	endfunction : rxpdo_ok

	function automatic logic state_next_ok(input st_t r, input st_t s,
		input logic cfg);
		if (r <= s)
			return 1'b1;
		if (r != up_one(s))
			return 1'b0;
		return !(r != fieldbus_sync_pkg::ST_PREOP && cfg);
	endfunction : state_next_ok

	// Communication state
	st_t        state_reg;
	st_t        state_next;
	logic       ack_reg;
	logic       ack_next;
	logic       err_reg;
	logic       err_next;
	logic [1:0] code_reg;
	logic [1:0] code_next;
	logic       bad_cfg;

	// Free-run with a cyclic motion mode is a configuration that cannot run
	assign bad_cfg = !dc_mode && cyclic_mode;

	always_comb
	begin
		state_next = state_reg;
		ack_next   = 1'b0;
		err_next   = err_reg;
		code_next  = code_reg;
		if (req_valid)
		begin
			if (req_state > state_reg && req_state != up_one(state_reg))
			begin
				err_next  = 1'b1;
				code_next = fieldbus_sync_pkg::ERR_SKIP;
			end
			else if (req_state > state_reg &&
				req_state != fieldbus_sync_pkg::ST_PREOP && bad_cfg)
			begin
				err_next  = 1'b1;
				code_next = fieldbus_sync_pkg::ERR_CONFIG;
			end
			else
			begin
				// Up by one, or any jump downward
				state_next = req_state;
				ack_next   = 1'b1;
				err_next   = 1'b0;
				code_next  = fieldbus_sync_pkg::ERR_NONE;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= fieldbus_sync_pkg::ST_INIT;
			ack_reg   <= 1'b0;
			err_reg   <= 1'b0;
			code_reg  <= fieldbus_sync_pkg::ERR_NONE;
		end
		else
		begin
			state_reg <= state_next;
			ack_reg   <= ack_next;
			err_reg   <= err_next;
			code_reg  <= code_next;
		end
	end

	assign comm_state   = state_reg;
	assign req_ack      = ack_reg;
	assign req_err      = err_reg;
	assign req_err_code = code_reg;

	// Mailbox / SDO
	logic          sdo_v_reg;
	logic          sdo_v_next;
	logic [15:0]   hdr_reg;
	logic [15:0]   hdr_next;
	logic [LW-1:0] len_reg;
	logic [LW-1:0] len_next;
	logic          rej_reg;
	logic          rej_next;
	logic          too_long;

	assign mbx_ready = mbx_ok(state_reg) && (!sdo_v_reg || sdo_ready);
	assign too_long = mbx_classic ?
		(mbx_len > LW'(fieldbus_sync_pkg::CLASSIC_SDO_BYTES)) :
		(mbx_len > LW'(MBX_MAX));

	always_comb
	begin
		sdo_v_next = sdo_v_reg;
		hdr_next   = hdr_reg;
		len_next   = len_reg;
		rej_next   = 1'b0;
		if (sdo_v_reg && sdo_ready)
			sdo_v_next = 1'b0;
		if (!mbx_ok(state_reg))
			sdo_v_next = 1'b0;
		else if (mbx_valid && mbx_ready)
		begin
			if (too_long)
				rej_next = 1'b1;
			else
			begin
				sdo_v_next = 1'b1;
				// Header forwarded as received; only the payload grows
				hdr_next   = mbx_hdr;
				len_next   = mbx_len;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sdo_v_reg <= 1'b0;
			hdr_reg   <= 16'h0000;
			len_reg   <= '0;
			rej_reg   <= 1'b0;
		end
		else
		begin
			sdo_v_reg <= sdo_v_next;
			hdr_reg   <= hdr_next;
			len_reg   <= len_next;
			rej_reg   <= rej_next;
		end
	end

	assign sdo_valid  = sdo_v_reg;
	assign sdo_hdr    = hdr_reg;
	assign sdo_len    = len_reg;
	assign mbx_reject = rej_reg;

	// Receive PDO path, master to drive
	logic             dec_busy;
	logic             dec_done;
	logic [PDO_W-1:0] dec_out;
	logic             rx_take;
	logic [PDO_W-1:0] held_reg;
	logic [PDO_W-1:0] held_next;
	logic             full_reg;
	logic             full_next;
	logic [PDO_W-1:0] cmd_reg;
	logic [PDO_W-1:0] cmd_next;
	logic             cmdv_reg;
	logic             cmdv_next;
	logic             late_reg;
	logic             late_next;
	logic             miss_reg;
	logic             miss_next;

	assign rx_ready = rxpdo_ok(state_reg);
	assign rx_take  = rx_valid && rx_ready;

	pdo_decode #(
		.W   (PDO_W),
		.LAT (DEC_LAT)
	) pdo_decode_inst (
		.clk   (clk),
		.nrst  (nrst),
		.start (rx_take),
		.din   (rx_data),
		.busy  (dec_busy),
		.done  (dec_done),
		.dout  (dec_out)
	);

	always_comb
	begin
		held_next = held_reg;
		full_next = full_reg;
		cmd_next  = cmd_reg;
		cmdv_next = 1'b0;
		late_next = 1'b0;
		miss_next = 1'b0;
		if (!rxpdo_ok(state_reg))
			full_next = 1'b0;
		else if (!dc_mode)
		begin
			// Aperiodic: each decoded frame goes out, unless cyclic mode
			if (dec_done && !cyclic_mode)
			begin
				cmd_next  = dec_out;
				cmdv_next = 1'b1;
			end
		end
		else
		begin
			if (dec_done)
			begin
				held_next = dec_out;
				full_next = 1'b1;
			end
			if (sync0)
			begin
				// A frame still decoding would arrive too late for this cycle
				late_next = dec_busy || rx_take;
				miss_next = !full_reg && !dec_busy && !rx_take;
				if (full_reg)
				begin
					cmd_next  = held_reg;
					cmdv_next = 1'b1;
					full_next = dec_done;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			held_reg <= '0;
			full_reg <= 1'b0;
			cmd_reg  <= '0;
			cmdv_reg <= 1'b0;
			late_reg <= 1'b0;
			miss_reg <= 1'b0;
		end
		else
		begin
			held_reg <= held_next;
			full_reg <= full_next;
			cmd_reg  <= cmd_next;
			cmdv_reg <= cmdv_next;
			late_reg <= late_next;
			miss_reg <= miss_next;
		end
	end

	assign drive_cmd_valid = cmdv_reg;
	assign drive_cmd       = cmd_reg;
	assign late_fault      = late_reg;
	assign data_miss       = miss_reg;
	assign mode_fault      = bad_cfg && txpdo_ok(state_reg);

	// Transmit PDO path, drive to master
	logic             txv_reg;
	logic             txv_next;
	logic [PDO_W-1:0] txd_reg;
	logic [PDO_W-1:0] txd_next;
	logic             tx_evt;

	// Sampling on the sync edge keeps inputs coherent with outputs
	assign tx_evt = dc_mode ? sync0 : status_strobe;

	always_comb
	begin
		txv_next = txv_reg;
		txd_next = txd_reg;
		if (txv_reg && tx_ready)
			txv_next = 1'b0;
		if (!txpdo_ok(state_reg))
			txv_next = 1'b0;
		else if (tx_evt && (!txv_reg || tx_ready))
		begin
			txv_next = 1'b1;
			txd_next = drive_status;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			txv_reg <= 1'b0;
			txd_reg <= '0;
		end
		else
		begin
			txv_reg <= txv_next;
			txd_reg <= txd_next;
		end
	end

	assign tx_valid = txv_reg;
	assign tx_data  = txd_reg;

	a_skip_refused: assert property (@(posedge clk) disable iff (!nrst)
		req_valid && req_state > state_reg && req_state != up_one(state_reg)
		|=> req_err && req_err_code == fieldbus_sync_pkg::ERR_SKIP
			&& $stable(state_reg))
		else $error("level skip was not refused");

	a_down_jump: assert property (@(posedge clk) disable iff (!nrst)
		req_valid && req_state < state_reg
		|=> state_reg == $past(req_state) && req_ack)
		else $error("downward jump not taken");

	a_err_report: assert property (@(posedge clk) disable iff (!nrst)
		req_valid && !state_next_ok(req_state, state_reg, bad_cfg)
		|=> req_err && !req_ack)
		else $error("failed change not reported");

	a_hold_state: assert property (@(posedge clk) disable iff (!nrst)
		!req_valid |=> $stable(state_reg))
		else $error("state moved without request");

	a_init_silent: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == fieldbus_sync_pkg::ST_INIT
		|-> !mbx_ready && !rx_ready ##1 !sdo_valid && !tx_valid)
		else $error("traffic served in init");

	a_safeop_rx_off: assert property (@(posedge clk) disable iff (!nrst)
		state_reg != fieldbus_sync_pkg::ST_OP && $past(state_reg) !=
			fieldbus_sync_pkg::ST_OP |-> !drive_cmd_valid && !rx_ready)
		else $error("receive outputs active below operational");

	a_classic_limit: assert property (@(posedge clk) disable iff (!nrst)
		mbx_valid && mbx_ready && mbx_classic &&
		mbx_len > LW'(fieldbus_sync_pkg::CLASSIC_SDO_BYTES)
		|=> mbx_reject && $stable(sdo_hdr))
		else $error("oversize classic SDO accepted");

	a_hdr_kept: assert property (@(posedge clk) disable iff (!nrst)
		mbx_valid && mbx_ready && !too_long
		|=> sdo_valid && sdo_hdr == $past(mbx_hdr) && sdo_len == $past(mbx_len))
		else $error("mailbox header altered");

	a_sync_apply: assert property (@(posedge clk) disable iff (!nrst)
		dc_mode && sync0 && full_reg && rxpdo_ok(state_reg)
		|=> drive_cmd_valid && drive_cmd == $past(held_reg))
		else $error("held data not applied on sync");

	a_dc_wait: assert property (@(posedge clk) disable iff (!nrst)
		$past(dc_mode) && !$past(sync0) |-> !drive_cmd_valid)
		else $error("distributed-clock data applied off sync");

	a_freerun_apply: assert property (@(posedge clk) disable iff (!nrst)
		!dc_mode && !cyclic_mode && rx_take && rxpdo_ok(state_reg)
		// Four decode cycles, done pulse, then the registered apply
		##1 (!rx_valid && !dc_mode && !cyclic_mode && rxpdo_ok(state_reg))
			[*5] |-> ##1 drive_cmd_valid)
		else $error("free-run data not applied after decode");

endmodule : fieldbus_slave_state_sync

//--- testbench/master_model.sv
`timescale 1ns/1ns
// Master side of the link; released lines carry inverted data
module master_model #(
	parameter int W = fieldbus_sync_pkg::PDO_W
)(
	input  wire logic                                    clk,
	input  wire logic                                    rx_ready,
	input  wire logic                                    mbx_ready,
	output logic                                         req_valid,
	output fieldbus_sync_pkg::comm_state_t               req_state,
	output logic                                         rx_valid,
	output logic [W-1:0]                                 rx_data,
	output logic                                         mbx_valid,
	output logic                                         mbx_classic,
	output logic [fieldbus_sync_pkg::MBX_HDR_W-1:0]      mbx_hdr,
	output logic [fieldbus_sync_pkg::MBX_LEN_W-1:0]      mbx_len
);
	initial
	begin
		{req_valid, rx_valid, mbx_valid, mbx_classic} = 4'h0;
		req_state = fieldbus_sync_pkg::ST_INIT;
		{rx_data, mbx_hdr, mbx_len} = '0;
	end

	// Bounded, so a stuck ready shows as mismatches instead of a hang
	task hold(input bit is_rx);
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			if ((is_rx ? rx_ready : mbx_ready) === 1'b1)
				break;
		end
		@(posedge clk);
		#1;
	endtask : hold

	// Requests only what the bench asks, skips included
	task req(input logic [1:0] s);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_state = fieldbus_sync_pkg::comm_state_t'(s);
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		req_state = fieldbus_sync_pkg::comm_state_t'(~s);
	endtask : req

	// Data is sent when the bench calls, well ahead of a sync event or just before one
	task rx(input logic [W-1:0] d);
		@(posedge clk);
		#1;
		rx_valid = 1'b1;
		rx_data = d;
		hold(1'b1);
		rx_valid = 1'b0;
		rx_data = ~d;
	endtask : rx

	task mbx(input logic c, input logic [15:0] h, input logic [7:0] l);
		@(posedge clk);
		#1;
		mbx_valid = 1'b1;
		{mbx_classic, mbx_hdr, mbx_len} = {c, h, l};
		hold(1'b0);
		mbx_valid = 1'b0;
		{mbx_classic, mbx_hdr, mbx_len} = ~{c, h, l};
	endtask : mbx
endmodule : master_model

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam int W = fieldbus_sync_pkg::PDO_W;
	logic                           clk, nrst, dc_mode, cyclic_mode, sync0;
	logic                           status_strobe, sdo_ready, tx_ready;
	logic                           req_valid, rx_valid, mbx_valid;
	logic                           mbx_classic, req_ack, req_err, mbx_ready;
	logic                           mbx_reject, sdo_valid, rx_ready, tx_valid;
	logic                           drive_cmd_valid, late_fault, data_miss;
	logic                           mode_fault;
	fieldbus_sync_pkg::comm_state_t req_state, comm_state;
	logic [1:0]                     req_err_code;
	logic [15:0]                    mbx_hdr, sdo_hdr;
	logic [7:0]                     mbx_len, sdo_len;
	logic [W-1:0]                   rx_data, drive_cmd, drive_status, tx_data;
	logic [W-1:0]                   exp_cmd[$], exp_tx[$], d;
	logic [23:0]                    exp_sdo[$];
	logic [7:0]                     lens[4] = '{8'h08, 8'h09, 8'h64, 8'h81};
	logic [31:0]                    seed = 32'h00008633;
	int                             miscompares, n_checks, cycles;

	fieldbus_slave_state_sync fieldbus_slave_state_sync_inst (
		.clk(clk), .nrst(nrst), .dc_mode(dc_mode), .cyclic_mode(cyclic_mode),
		.sync0(sync0), .req_valid(req_valid), .req_state(req_state),
		.comm_state(comm_state), .req_ack(req_ack), .req_err(req_err),
		.req_err_code(req_err_code), .mbx_valid(mbx_valid),
		.mbx_ready(mbx_ready), .mbx_classic(mbx_classic), .mbx_hdr(mbx_hdr),
		.mbx_len(mbx_len), .mbx_reject(mbx_reject), .sdo_valid(sdo_valid),
		.sdo_ready(sdo_ready), .sdo_hdr(sdo_hdr), .sdo_len(sdo_len),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.drive_cmd_valid(drive_cmd_valid), .drive_cmd(drive_cmd),
		.late_fault(late_fault), .data_miss(data_miss),
		.mode_fault(mode_fault), .status_strobe(status_strobe),
		.drive_status(drive_status), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data)
	);

	master_model master_model_inst (
		.clk(clk), .rx_ready(rx_ready), .mbx_ready(mbx_ready),
		.req_valid(req_valid), .req_state(req_state), .rx_valid(rx_valid),
		.rx_data(rx_data), .mbx_valid(mbx_valid), .mbx_classic(mbx_classic),
		.mbx_hdr(mbx_hdr), .mbx_len(mbx_len)
	);

	always #20 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task wrap_up();
		chk("pending", '0,
			exp_cmd.size() + exp_tx.size() + exp_sdo.size());
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	task chk(input string what, input logic [W-1:0] e, input logic [W-1:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task step();
		@(posedge clk);
		#1;
	endtask : step

	task do_req(input logic [1:0] s, input logic [1:0] es,
		input logic [1:0] code);
		master_model_inst.req(s);
		chk("comm_state", es, comm_state);
		chk("req_ack", code == 2'h0, req_ack);
		chk("req_err", code != 2'h0, req_err);
		chk("req_err_code", code, req_err_code);
	endtask : do_req

	// Sync or strobe event; tx word expected only from Safe-Operational up
	task event_pulse(input bit use_sync, input bit cmd, input logic [W-1:0] v);
		step();
		{sync0, status_strobe} = {use_sync, !use_sync};
		drive_status = {rnd(), rnd()};
		if (comm_state >= fieldbus_sync_pkg::ST_SAFEOP)
			exp_tx.push_back(drive_status);
		step();
		{sync0, status_strobe} = 2'h0;
		if (cmd)
			exp_cmd.push_back(v);
		chk("drive_cmd_valid", cmd, drive_cmd_valid);
	endtask : event_pulse

	// An output with no note waiting is compared against its own inverse
	always @(posedge clk)
	begin
		if (nrst === 1'b1 && drive_cmd_valid === 1'b1)
			chk("drive_cmd", exp_cmd.size() ? exp_cmd.pop_front() : ~drive_cmd,
				drive_cmd);
		if (nrst === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1)
			chk("tx_data", exp_tx.size() ? exp_tx.pop_front() : ~tx_data,
				tx_data);
		if (nrst === 1'b1 && sdo_valid === 1'b1 && sdo_ready === 1'b1)
			chk("sdo", exp_sdo.size() ? exp_sdo.pop_front() : ~{sdo_hdr, sdo_len},
				{sdo_hdr, sdo_len});
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	initial
	begin
		{clk, nrst, sync0, status_strobe, cyclic_mode} = 5'h00;
		{dc_mode, sdo_ready, tx_ready} = 3'h7;
		drive_status = '0;
		repeat (10) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk("mbx_ready", 1'b0, mbx_ready);
		do_req(2'h2, 2'h0, 2'h1);
		do_req(2'h1, 2'h1, 2'h0);
		chk("rx_ready", 1'b0, rx_ready);
		event_pulse(1'b1, 1'b0, '0);
		for (int i = 0; i < 4; i++)
		begin
			d = {rnd(), rnd()};
			if (!i[0])
				exp_sdo.push_back({d[15:0], lens[i]});
			master_model_inst.mbx(i < 2, d[15:0], lens[i]);
			chk("mbx_reject", i[0], mbx_reject);
		end
		do_req(2'h3, 2'h1, 2'h1);
		{dc_mode, cyclic_mode} = 2'h1;
		do_req(2'h2, 2'h1, 2'h2);
		{dc_mode, cyclic_mode} = 2'h2;
		do_req(2'h2, 2'h2, 2'h0);
		chk("rx_ready", 1'b0, rx_ready);
		event_pulse(1'b1, 1'b0, '0);
		do_req(2'h3, 2'h3, 2'h0);
		for (int i = 0; i < 3; i++)
		begin
			d = {rnd(), rnd()};
			master_model_inst.rx(d);
			repeat (8) step();
			event_pulse(1'b1, 1'b1, d);
			chk("late_miss", 1'b0, late_fault | data_miss);
		end
		event_pulse(1'b1, 1'b0, '0);
		chk("data_miss", 1'b1, data_miss);
		d = {rnd(), rnd()};
		master_model_inst.rx(d);
		event_pulse(1'b1, 1'b0, '0);
		chk("late_fault", 1'b1, late_fault);
		repeat (4) step();
		event_pulse(1'b1, 1'b1, d);
		dc_mode = 1'b0;
		d = {rnd(), rnd()};
		exp_cmd.push_back(d);
		master_model_inst.rx(d);
		repeat (10) step();
		event_pulse(1'b0, 1'b0, '0);
		cyclic_mode = 1'b1;
		step();
		chk("mode_fault", 1'b1, mode_fault);
		master_model_inst.rx({rnd(), rnd()});
		repeat (10) step();
		{dc_mode, cyclic_mode} = 2'h2;
		do_req(2'h0, 2'h0, 2'h0);
		chk("mbx_ready", 1'b0, mbx_ready);
		repeat (5) step();
		wrap_up();
	end
endmodule : testbench
